// ---- pvsp_defines.vh ----
`ifndef PVSP_DEFINES_VH
`define PVSP_DEFINES_VH

// System clock and derived bit-clock half periods
`define PVSP_CLK_HZ 50000000
`define PVSP_BCLK_128K_HZ 128000
`define PVSP_BCLK_256K_HZ 256000
`define PVSP_BCLK_512K_HZ 512000
`define PVSP_HALF_128K (`PVSP_CLK_HZ / (2 * `PVSP_BCLK_128K_HZ))
`define PVSP_HALF_256K (`PVSP_CLK_HZ / (2 * `PVSP_BCLK_256K_HZ))
`define PVSP_HALF_512K (`PVSP_CLK_HZ / (2 * `PVSP_BCLK_512K_HZ))
// Frame length in bits at 128 kHz and 8 kHz frames
`define PVSP_FRAME_HZ 8000
`define PVSP_FRAME_BITS_128K (`PVSP_BCLK_128K_HZ / `PVSP_FRAME_HZ)

// Register byte addresses
`define PVSP_A_CFG 8'h00
`define PVSP_A_SLOT 8'h04
`define PVSP_A_DIV 8'h08
`define PVSP_A_STAT 8'h0c
`define PVSP_A_TX0 8'h10
`define PVSP_A_TX1 8'h14
`define PVSP_A_TX2 8'h18
`define PVSP_A_RX0 8'h20
`define PVSP_A_RX1 8'h24
`define PVSP_A_RX2 8'h28

// Reset values
`define PVSP_CFG_RST 32'h0000_0000
`define PVSP_SLOT_RST 32'h0000_0000
`define PVSP_DIV_RST 32'h0002_0000

// Fields of port_config_word
`define PVSP_F_EN 0
`define PVSP_F_MASTER 1
`define PVSP_F_FRM 2
`define PVSP_F_SLOT16 4
`define PVSP_F_FMT 5
`define PVSP_F_LITTLE 7
`define PVSP_F_PAD 8
`define PVSP_F_ATT 10
`define PVSP_F_MUTE 13
`define PVSP_F_SYNC_OFF 14
`define PVSP_F_ZFALL 15
`define PVSP_F_FAST 16
`define PVSP_F_LONG16 17
`define PVSP_F_RATE 18

// Encodings
`define PVSP_FRM_LONG 2'h0
`define PVSP_FRM_SHORT 2'h1
`define PVSP_FRM_GCI 2'h2
`define PVSP_FMT_ULAW 2'h0
`define PVSP_FMT_ALAW 2'h1
`define PVSP_FMT_LIN13 2'h2
`define PVSP_FMT_LIN16 2'h3
`define PVSP_PAD_SIGN 2'h0
`define PVSP_PAD_ZERO 2'h1
`define PVSP_PAD_ATT 2'h2

// Sync lengths and limits
`define PVSP_SYNC_BITS 11'h008
`define PVSP_SYNC16_BITS 11'h010
`define PVSP_NUM_SLOTS 7'h04
`define PVSP_POS_IDLE 11'h7ff

`endif

// ---- pvsp_sync2.v ----
`timescale 1ns/100ps
module pvsp_sync2 (
    input wire sys_clk, // System clock
    input wire nrst, // Async reset, active low
    input wire ce, // Clock enable
    input wire [2:0] d, // Pin levels
    output wire [2:0] q // Synchronised levels
);
    reg [2:0] meta_ff;
    reg [2:0] sync_ff;

    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            meta_ff <= 3'h0;
            sync_ff <= 3'h0;
        end else if (ce) begin
            meta_ff <= d;
            sync_ff <= meta_ff;
        end
    end

    assign q = sync_ff;
endmodule

// ---- pvsp_port.v ----
// What this block does
// R01: Master drives clock and sync, slave follows
// R02: Long sync rising edge starts word
// R03: Master long sync high eight bits
// R04: Slave accepts any long sync width
// R05: Sample input falling, launch output rising
// R06: Release output on LSB fall or rise
// R07: Short sync one bit, falling starts word
// R08: Three connections over first four slots
// R09: GCI gives two 64 kbps B channels
// R10: GCI frame starts on sync rise, 8 kHz
// R11: Slot length 8 or 16, 8 needs 8-bit
// R12: Formats 13, 16 linear or companded 8
// R13: One sample per slot per frame
// R14: Little or big endian bit order
// R15: Spare bits sign, zero or attenuation
// R16: Mute drives output zero
// R17: Master may hold sync low, clock runs
// R18: Slow source gives 128, 256, 512 kHz
// R19: Fast source long sync 8 or 16
// R20: Slots follow contiguously from frame start
//
// The APB register port and the address map were decided locally.
`timescale 1ns/100ps
`include "pvsp_defines.vh"
module pvsp_port (
    input wire sys_clk, // 50 MHz system clock
    input wire nrst, // Async reset, active low
    input wire ce, // Clock enable, freezes all state when low
    input wire psel, // APB select
    input wire penable, // APB enable
    input wire pwrite, // APB direction
    input wire [7:0] paddr, // APB byte address
    input wire [31:0] pwdata, // APB write data
    output wire [31:0] prdata, // APB read data
    output wire pready, // APB ready
    output wire pslverr, // APB error on unmapped address
    input wire pcm_clk_i, // Bit clock pin level
    output wire pcm_clk_o, // Bit clock drive value
    output wire pcm_clk_oe, // Bit clock drive enable
    input wire pcm_sync_i, // Frame sync pin level
    output wire pcm_sync_o, // Frame sync drive value
    output wire pcm_sync_oe, // Frame sync drive enable
    input wire pcm_in, // Serial data in
    output wire pcm_out_o, // Serial data out value
    output wire pcm_out_oe // Serial data out enable
);
    reg [31:0] cfg_ff;
    reg [31:0] slot_ff;
    reg [31:0] div_ff;
    reg [15:0] tx_ff [0:2];
    reg [15:0] rx_ff [0:2];
    reg [2:0] rx_new_ff;
    reg [31:0] prdata_ff;
    reg pready_ff;
    reg pslverr_ff;
    reg [15:0] div_cnt_ff;
    reg bclk_ff;
    reg clk_d_ff;
    reg sync_d_ff;
    reg sfs_arm_ff;
    reg [10:0] bit_pos_ff;
    reg cur_act_ff;
    reg [1:0] cur_k_ff;
    reg [3:0] cur_idx_ff;
    reg cur_last_ff;
    reg [15:0] tx_lat_ff;
    reg [15:0] rx_sh_ff;
    reg out_ff;
    reg out_oe_ff;
    reg sync_o_ff;
    reg drv_ff;
    integer i, ri, ti;
    wire [2:0] pin_s;
    wire clk_s = pin_s[0];
    wire sync_s = pin_s[1];
    wire in_s = pin_s[2];

    pvsp_sync2 u_sync (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .ce(ce),
        .d({pcm_in, pcm_sync_i, pcm_clk_i}),
        .q(pin_s)
    );

    wire en = cfg_ff[`PVSP_F_EN];
    wire master = cfg_ff[`PVSP_F_MASTER];
    wire [1:0] frm = cfg_ff[`PVSP_F_FRM+1:`PVSP_F_FRM];
    wire gci = (frm == `PVSP_FRM_GCI);
    wire short_fs = (frm == `PVSP_FRM_SHORT);
    wire [1:0] fmt = cfg_ff[`PVSP_F_FMT+1:`PVSP_F_FMT];
    wire little = cfg_ff[`PVSP_F_LITTLE];
    wire [1:0] pad = cfg_ff[`PVSP_F_PAD+1:`PVSP_F_PAD];
    wire [2:0] att = cfg_ff[`PVSP_F_ATT+2:`PVSP_F_ATT];
    wire mute = cfg_ff[`PVSP_F_MUTE];
    wire sync_off = cfg_ff[`PVSP_F_SYNC_OFF];
    wire zfall = cfg_ff[`PVSP_F_ZFALL];
    wire fast = cfg_ff[`PVSP_F_FAST];
    wire long16 = cfg_ff[`PVSP_F_LONG16];
    wire [1:0] rate = cfg_ff[`PVSP_F_RATE+1:`PVSP_F_RATE];
    // GCI carries 8-bit B channels only
    wire slot16 = cfg_ff[`PVSP_F_SLOT16] & ~gci;

    // R15 spare bits fill
    function [15:0] fmt_word;
        input [15:0] s;
        input wide;
        input [1:0] f;
        input [1:0] p;
        input [2:0] a;
        begin
            // R11 short slot forces 8-bit
            if (!wide) begin
                fmt_word = {8'h00, s[7:0]};
            end else if (f == `PVSP_FMT_LIN16) begin
                fmt_word = s;
            end else if (f == `PVSP_FMT_LIN13) begin
                case (p)
                    `PVSP_PAD_SIGN: fmt_word = {{3{s[12]}}, s[12:0]};
                    `PVSP_PAD_ATT: fmt_word = {s[12:0], a};
                    default: fmt_word = {3'h0, s[12:0]};
                endcase
            end else begin
                case (p)
                    `PVSP_PAD_SIGN: fmt_word = {{8{s[7]}}, s[7:0]};
                    `PVSP_PAD_ATT: fmt_word = {s[7:0], 5'h00, a};
                    default: fmt_word = {8'h00, s[7:0]};
                endcase
            end
        end
    endfunction

    // R18 slow source rates
    localparam integer HALF_128K = `PVSP_HALF_128K;
    localparam integer HALF_256K = `PVSP_HALF_256K;
    localparam integer HALF_512K = `PVSP_HALF_512K;
    localparam integer FRAME_128K = `PVSP_FRAME_BITS_128K;
    wire [15:0] half_128k = HALF_128K[15:0];
    wire [15:0] half_256k = HALF_256K[15:0];
    wire [15:0] half_512k = HALF_512K[15:0];
    wire [10:0] frame_128k = FRAME_128K[10:0];
    reg [15:0] half_sel;
    reg [10:0] flen;
    always @* begin
        case (rate)
            2'h0: half_sel = half_128k;
            2'h1: half_sel = half_256k;
            default: half_sel = half_512k;
        endcase
        // R10 frames at 8 kHz at slow rates 0 to 2
        flen = fast ? {div_ff[23:16], 3'h0} : (frame_128k << rate);
        if (fast) begin
            half_sel = div_ff[15:0];
        end
    end

    wire [15:0] cnt_inc = div_cnt_ff + 16'h0001;
    wire tick = en & master & (cnt_inc >= half_sel);
    // R01 edges from own clock or the pin
    wire rise_ev = en & (master ? (tick & ~bclk_ff) : (clk_s & ~clk_d_ff));
    wire fall_ev = en & (master ? (tick & bclk_ff) : (~clk_s & clk_d_ff));
    // R02 slave word start on sync rise
    wire s_start = en & ~master & ~short_fs & sync_s & ~sync_d_ff;
    wire launch = rise_ev | s_start;
    wire [10:0] pos_inc = bit_pos_ff + 11'h001;
    reg [10:0] np;
    always @* begin
        if (s_start) begin
            np = 11'h000;
        end else if (master) begin
            np = (pos_inc >= flen) ? 11'h000 : pos_inc;
        end else if (sfs_arm_ff) begin
            // R07 word starts after short sync
            np = 11'h000;
        end else begin
            // R04 slave tolerates any sync width
            np = (bit_pos_ff == `PVSP_POS_IDLE) ? bit_pos_ff : pos_inc;
        end
    end

    // R20 slots contiguous from frame start
    wire [6:0] np_slot = slot16 ? np[10:4] : np[9:3];
    wire [3:0] np_bit = slot16 ? np[3:0] : {1'b0, np[2:0]};
    wire [3:0] last_bit = slot16 ? 4'hf : 4'h7;
    // R14 bit order
    wire [3:0] np_idx = little ? np_bit : (last_bit - np_bit);

    reg hit;
    reg [1:0] hk;
    always @* begin
        hit = 1'b0;
        hk = 2'h0;
        for (i = 2; i >= 0; i = i - 1) begin
            // R08 up to three connections
            // R09 GCI maps B1, B2 to slots 0, 1
            if ((gci ? (i < 2) : slot_ff[i*3+2]) && (np_slot < `PVSP_NUM_SLOTS) &&
                (np_slot[1:0] == (gci ? i[1:0] : slot_ff[i*3 +: 2]))) begin
                hit = 1'b1;
                hk = i[1:0];
            end
        end
    end

    // R12 sample latched at slot start
    wire [15:0] slot_word = (np_bit == 4'h0) ? fmt_word(tx_ff[hk], slot16, fmt, pad, att) : tx_lat_ff;
    // R03 R19 long sync length
    wire [10:0] slen = (fast & long16) ? `PVSP_SYNC16_BITS : `PVSP_SYNC_BITS;
    wire m_sync = short_fs ? (np == (flen - 11'h001)) : (np < slen);
    reg [15:0] nxt_rx_sh;
    always @* begin
        nxt_rx_sh = rx_sh_ff;
        nxt_rx_sh[cur_idx_ff] = in_s;
    end

    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            div_cnt_ff <= 16'h0000;
            bclk_ff <= 1'b0;
            clk_d_ff <= 1'b0;
            sync_d_ff <= 1'b0;
            sfs_arm_ff <= 1'b0;
            bit_pos_ff <= `PVSP_POS_IDLE;
            cur_act_ff <= 1'b0;
            cur_k_ff <= 2'h0;
            cur_idx_ff <= 4'h0;
            cur_last_ff <= 1'b0;
            tx_lat_ff <= 16'h0000;
            rx_sh_ff <= 16'h0000;
            out_ff <= 1'b0;
            out_oe_ff <= 1'b0;
            sync_o_ff <= 1'b0;
            drv_ff <= 1'b0;
        end else if (ce) begin
            clk_d_ff <= clk_s;
            sync_d_ff <= sync_s;
            // R01 master owns clock and sync pins
            drv_ff <= en & master;
            if (!en || !master) begin
                div_cnt_ff <= 16'h0000;
                bclk_ff <= 1'b0;
                sync_o_ff <= 1'b0;
            end else if (tick) begin
                div_cnt_ff <= 16'h0000;
                bclk_ff <= ~bclk_ff;
            end else begin
                div_cnt_ff <= cnt_inc;
            end
            if (!en) begin
                bit_pos_ff <= `PVSP_POS_IDLE;
                sfs_arm_ff <= 1'b0;
                cur_act_ff <= 1'b0;
                out_oe_ff <= 1'b0;
                out_ff <= 1'b0;
            end else begin
                // R05 launch on rising edge
                if (launch) begin
                    bit_pos_ff <= np;
                    sfs_arm_ff <= 1'b0;
                    cur_act_ff <= hit;
                    cur_k_ff <= hk;
                    cur_idx_ff <= np_idx;
                    cur_last_ff <= (np_bit == last_bit);
                    tx_lat_ff <= slot_word;
                    // R16 mute
                    out_ff <= hit & ~mute & slot_word[np_idx];
                    out_oe_ff <= hit;
                    if (master) begin
                        // R17 sync may be held low
                        sync_o_ff <= m_sync & ~sync_off;
                    end
                end
                // R05 capture on falling edge
                if (fall_ev) begin
                    sfs_arm_ff <= ~master & short_fs & sync_s;
                    if (cur_act_ff) begin
                        rx_sh_ff <= nxt_rx_sh;
                    end
                    // R06 early release in LSB
                    if (zfall && cur_last_ff) begin
                        out_oe_ff <= 1'b0;
                    end
                end
            end
        end
    end

    wire rx_done = en & fall_ev & cur_act_ff & cur_last_ff;
    wire apb_acc = psel & penable & pready_ff;
    wire apb_wr = apb_acc & pwrite;
    wire [2:0] rx_clr = (apb_wr && paddr == `PVSP_A_STAT) ? pwdata[2:0] : 3'h0;
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rx_new_ff <= 3'h0;
            for (ri = 0; ri < 3; ri = ri + 1) begin
                rx_ff[ri] <= 16'h0000;
            end
        end else if (ce) begin
            // R13 one sample per slot per frame; set wins over clear
            rx_new_ff <= (rx_new_ff & ~rx_clr) | (rx_done ? (3'h1 << cur_k_ff) : 3'h0);
            if (rx_done) begin
                rx_ff[cur_k_ff] <= slot16 ? nxt_rx_sh : {8'h00, nxt_rx_sh[7:0]};
            end
        end
    end

    reg [31:0] rd_mux;
    reg rd_err;
    always @* begin
        rd_err = 1'b0;
        case (paddr)
            `PVSP_A_CFG: rd_mux = cfg_ff;
            `PVSP_A_SLOT: rd_mux = slot_ff;
            `PVSP_A_DIV: rd_mux = div_ff;
            `PVSP_A_STAT: rd_mux = {16'h0000, bit_pos_ff, cur_act_ff, out_oe_ff, rx_new_ff};
            `PVSP_A_TX0: rd_mux = {16'h0000, tx_ff[0]};
            `PVSP_A_TX1: rd_mux = {16'h0000, tx_ff[1]};
            `PVSP_A_TX2: rd_mux = {16'h0000, tx_ff[2]};
            `PVSP_A_RX0: rd_mux = {16'h0000, rx_ff[0]};
            `PVSP_A_RX1: rd_mux = {16'h0000, rx_ff[1]};
            `PVSP_A_RX2: rd_mux = {16'h0000, rx_ff[2]};
            default: begin
                rd_mux = 32'h0000_0000;
                rd_err = 1'b1;
            end
        endcase
    end
    // One wait state keeps ready and read data registered
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
            cfg_ff <= `PVSP_CFG_RST;
            slot_ff <= `PVSP_SLOT_RST;
            div_ff <= `PVSP_DIV_RST;
            for (ti = 0; ti < 3; ti = ti + 1) begin
                tx_ff[ti] <= 16'h0000;
            end
        end else if (ce) begin
            if (psel && penable && !pready_ff) begin
                pready_ff <= 1'b1;
                pslverr_ff <= rd_err;
                prdata_ff <= pwrite ? 32'h0000_0000 : rd_mux;
            end else begin
                pready_ff <= 1'b0;
                pslverr_ff <= 1'b0;
            end
            if (apb_wr) begin
                case (paddr)
                    `PVSP_A_CFG: cfg_ff <= pwdata;
                    `PVSP_A_SLOT: slot_ff <= pwdata;
                    `PVSP_A_DIV: div_ff <= pwdata;
                    `PVSP_A_TX0: tx_ff[0] <= pwdata[15:0];
                    `PVSP_A_TX1: tx_ff[1] <= pwdata[15:0];
                    `PVSP_A_TX2: tx_ff[2] <= pwdata[15:0];
                    default: cfg_ff <= cfg_ff;
                endcase
            end
        end
    end
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign pcm_clk_o = bclk_ff;
    assign pcm_clk_oe = drv_ff;
    assign pcm_sync_o = sync_o_ff;
    assign pcm_sync_oe = drv_ff;
    assign pcm_out_o = out_ff;
    assign pcm_out_oe = out_oe_ff;
endmodule

// ---- pvsp_chk.sv ----
`timescale 1ns/100ps
module pvsp_chk (
    input wire sys_clk, // Clock
    input wire nrst, // Reset, active low
    input wire psel, // APB select
    input wire penable, // APB enable
    input wire [7:0] paddr, // APB address
    input wire [31:0] prdata, // APB read data
    input wire pready, // APB ready
    input wire pslverr, // APB error
    input wire pcm_clk_o, // Bit clock
    input wire pcm_clk_oe, // Bit clock enable
    input wire pcm_sync_o, // Sync
    input wire pcm_sync_oe, // Sync enable
    input wire pcm_out_o, // Data
    input wire pcm_out_oe // Data enable
);
    reg [4:0] len_ff;
    reg ck_ff;
    reg sy_ff;
    wire mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h20, 8'h24, 8'h28};
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);
    // Sync width in bit-clock rises, saturating
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            len_ff <= 5'h00;
            ck_ff <= 1'b0;
            sy_ff <= 1'b0;
        end else begin
            ck_ff <= pcm_clk_o;
            sy_ff <= pcm_sync_o;
            if (pcm_sync_o && !sy_ff)
                len_ff <= 5'h01;
            else if (pcm_sync_o && pcm_clk_o && !ck_ff && len_ff != 5'h1f)
                len_ff <= len_ff + 5'h01;
        end
    end
    a_apb_answer: assert property (psel && $rose(penable) |=> pready) else $error("apb answer late");
    a_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
    a_err_map: assert property (pready |-> pslverr == !mapped && (mapped || prdata == 32'h0))
        else $error("pslverr wrong");
    a_oe_pair: assert property (pcm_clk_oe == pcm_sync_oe) else $error("clock and sync enables differ");
    a_sync_len: assert property (!pcm_sync_o && sy_ff && pcm_sync_oe && pcm_clk_o && !ck_ff |->
        len_ff inside {5'h01, 5'h08, 5'h10}) else $error("sync width wrong");
    a_out_launch: assert property ($changed(pcm_out_o) && pcm_out_oe && $past(pcm_out_oe) && pcm_clk_oe
        |-> pcm_clk_o) else $error("data changed with clock low");
    a_oe_launch: assert property ($rose(pcm_out_oe) && pcm_clk_oe |-> pcm_clk_o) else $error("drive off rise");
    a_sync_rise: assert property ($rose(pcm_sync_o) && pcm_sync_oe |-> pcm_clk_o) else $error("sync off rise");
endmodule

bind pvsp_port pvsp_chk u_pvsp_chk (.sys_clk, .nrst, .psel, .penable, .paddr, .prdata, .pready, .pslverr,
    .pcm_clk_o, .pcm_clk_oe, .pcm_sync_o, .pcm_sync_oe, .pcm_out_o, .pcm_out_oe);

// ---- pvsp_codec.sv ----
`timescale 1ns/100ps
module pvsp_codec (
    input wire sys_clk, // Bench clock
    input wire gen, // Codec makes clock and sync
    input wire short_frm, // Short sync framing
    input wire [31:0] tx_pat, // Frame sent MSB first
    input wire line_clk, // Bit clock line
    input wire line_sync, // Sync line
    input wire line_out, // Data from device
    output reg clk_drv = 1'b0, // Made clock
    output reg sync_drv = 1'b0, // Made sync
    output reg din = 1'b0, // Data to device
    output reg [31:0] word = 32'h0, // Last frame seen
    output reg [15:0] nfrm = 16'h0 // Frames seen
);
    reg [31:0] cap = 32'h0;
    reg [5:0] ridx = 6'h3f;
    reg sy_rise = 1'b0;
    reg sy_fall = 1'b0;
    integer i;
    always begin
        if (gen !== 1'b1) begin
            @(posedge sys_clk);
        end else begin
            for (i = -1; i < 32; i = i + 1) begin
                #3;
                clk_drv = 1'b1;
                sync_drv = short_frm ? (i == -1) : (i >= 0 && i < 3);
                #80;
                clk_drv = 1'b0;
                #77;
            end
            #400;
        end
    end
    // word start and one data bit launched per clock rise
    always @(posedge line_clk) begin
        #2;
        if (short_frm ? sy_fall : (line_sync && !sy_rise))
            ridx = 6'd0;
        else if (ridx != 6'h3f)
            ridx = ridx + 6'd1;
        sy_rise = line_sync;
        din = (ridx < 6'd32) ? tx_pat[31 - ridx] : ~din;
    end
    // device data taken on the fall, clear of its launch edge
    always @(negedge line_clk) begin
        sy_fall = line_sync;
        if (ridx < 6'd32)
            cap[31 - ridx] = line_out;
        if (ridx == 6'd31) begin
            word = cap;
            nfrm = nfrm + 16'h1;
        end
    end
endmodule

// ---- tb.sv ----
`timescale 1ns/100ps
module tb;
    reg sys_clk = 1'b0;
    reg nrst = 1'b0;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg [7:0] paddr = 8'h00;
    reg [31:0] pwdata = 32'h0;
    reg gen = 1'b0;
    reg short_frm = 1'b0;
    reg flip = 1'b0;
    reg [31:0] rd;
    reg err;
    wire [31:0] prdata;
    wire pready, pslverr, pcm_clk_o, pcm_clk_oe, pcm_sync_o, pcm_sync_oe, pcm_out_o, pcm_out_oe;
    wire clk_drv, sync_drv, pcm_in;
    wire [31:0] word;
    wire [15:0] nfrm;
    wire pcm_clk_i = pcm_clk_oe ? pcm_clk_o : (gen ? clk_drv : flip);
    wire pcm_sync_i = pcm_sync_oe ? pcm_sync_o : (gen ? sync_drv : flip);
    wire out_line = pcm_out_oe ? pcm_out_o : flip;
    integer miscompares = 0;
    integer cmp_count = 0;
    integer cyc = 0;
    pvsp_port u_pvsp_port (.sys_clk, .nrst, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .pcm_clk_i, .pcm_clk_o, .pcm_clk_oe, .pcm_sync_i, .pcm_sync_o, .pcm_sync_oe,
        .pcm_in, .pcm_out_o, .pcm_out_oe);
    pvsp_codec u_pvsp_codec (.sys_clk, .gen, .short_frm, .tx_pat(32'h3c96_5aa5), .line_clk(pcm_clk_i),
        .line_sync(pcm_sync_i), .line_out(out_line), .clk_drv, .sync_drv, .din(pcm_in), .word, .nfrm);
    always #10 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        flip <= ~flip;
        cyc = cyc + 1;
        if (cyc == 60000) begin
            miscompares = miscompares + 1;
            tally_and_finish;
        end
    end
    task tally_and_finish;
        begin
            $display("compares %0d mismatches %0d", cmp_count, miscompares);
            if (miscompares == 0 && cmp_count > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask
    task chk(input string name, input [31:0] exp, input [31:0] got);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("BAD %0s exp %h got %h", name, exp, got);
            end
        end
    endtask
    task apb(input w, input [7:0] a, input [31:0] d);
        begin
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge sys_clk);
            penable <= 1'b1;
            @(posedge sys_clk);
            while (pready !== 1'b1) begin
                @(posedge sys_clk);
            end
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge sys_clk);
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rdc(input string n, input [7:0] a, input [31:0] e);
        begin
            apb(1'b0, a, 32'h0);
            chk(n, e, rd);
        end
    endtask
    task wait_frm(input integer n);
        integer k;
        integer t;
        begin
            t = nfrm + n;
            k = 0;
            while (nfrm < t && k < 20000) begin
                @(posedge sys_clk);
                k = k + 1;
            end
            chk("frames", 32'h1, {31'h0, nfrm >= t});
        end
    endtask
    task t_regs;
        begin
            rdc("cfg", 8'h00, 32'h0);
            rdc("div", 8'h08, 32'h0002_0000);
            rdc("hole", 8'h30, 32'h0);
            chk("err_rd", 32'h1, {31'h0, err});
            wr(8'h1c, 32'hffff_ffff);
            chk("err_wr", 32'h1, {31'h0, err});
        end
    endtask
    task t_multi;
        begin
            wr(8'h10, 32'h0000_00a1);
            wr(8'h14, 32'h0000_004c);
            wr(8'h18, 32'h0000_0037);
            wr(8'h04, 32'h0000_01af);
            wr(8'h08, 32'h0004_0004);
            wr(8'h00, 32'h0001_0003);
            wait_frm(2);
            chk("slots", 32'h004c_37a1, {8'h00, word[23:0]});
            chk("clk_oe", 32'h1, {31'h0, pcm_clk_oe});
            rdc("rx0", 8'h20, 32'h0000_00a5);
            rdc("rx1", 8'h24, 32'h0000_0096);
            rdc("rx2", 8'h28, 32'h0000_005a);
            apb(1'b0, 8'h0c, 32'h0);
            chk("rx_new", 32'h7, rd & 32'h7);
            wr(8'h00, 32'h0001_2003);
            wait_frm(2);
            chk("mute", 32'h0, {8'h00, word[23:0]});
        end
    endtask
    task t_sync_off;
        integer k;
        integer hi;
        integer tg;
        reg last;
        begin
            k = 0;
            last = 1'b0;
            while (k < 2000 && !(last && pcm_sync_o === 1'b0)) begin
                last = pcm_sync_o;
                @(posedge sys_clk);
                k = k + 1;
            end
            wr(8'h00, 32'h0001_4003);
            hi = 0;
            tg = 0;
            last = pcm_clk_o;
            for (k = 0; k < 640; k = k + 1) begin
                @(posedge sys_clk);
                if (pcm_sync_o !== 1'b0)
                    hi = hi + 1;
                if (pcm_clk_o !== last)
                    tg = tg + 1;
                last = pcm_clk_o;
            end
            chk("sync_hi", 32'h0, hi);
            chk("clk_run", 32'h1, {31'h0, tg >= 159 && tg <= 161});
        end
    endtask
    task t_pad;
        integer j;
        reg [31:0] c;
        reg [15:0] t;
        reg [15:0] e;
        begin
            wr(8'h04, 32'h0000_0004);
            for (j = 0; j < 4; j = j + 1) begin
                case (j)
                    0: {c, t, e} = {32'h0001_0013, 16'h0083, 16'hff83};
                    1: {c, t, e} = {32'h0001_0053, 16'h1abc, 16'hfabc};
                    2: {c, t, e} = {32'h0001_0153, 16'h1abc, 16'h1abc};
                    default: {c, t, e} = {32'h0003_1653, 16'h0abc, 16'h55e5};
                endcase
                wr(8'h10, {16'h0, t});
                wr(8'h00, c);
                wait_frm(2);
                chk("pad", {16'h0, e}, {16'h0, word[31:16]});
            end
        end
    endtask
    task t_slave;
        begin
            gen <= 1'b1;
            short_frm <= 1'b1;
            wr(8'h04, 32'h0000_0005);
            wr(8'h10, 32'h0000_1234);
            wr(8'h00, 32'h0000_00f5);
            wait_frm(3);
            chk("clk_oe", 32'h0, {31'h0, pcm_clk_oe});
            chk("short_out", 32'h2c48, {16'h0, word[15:0]});
            rdc("short_rx", 8'h20, 32'h0000_a55a);
            short_frm <= 1'b0;
            wr(8'h04, 32'h0000_002c);
            wr(8'h10, 32'h0000_005a);
            wr(8'h14, 32'h0000_00c3);
            wr(8'h00, 32'h0000_0029);
            wait_frm(3);
            chk("gci_out", 32'h5ac3, {16'h0, word[31:16]});
            rdc("gci_rx0", 8'h20, 32'h0000_003c);
            rdc("gci_rx1", 8'h24, 32'h0000_0096);
        end
    endtask
    task t_slow;
        integer n;
        reg last;
        begin
            wr(8'h10, 32'h0000_00b6);
            wr(8'h04, 32'h0000_0004);
            wr(8'h00, 32'h0008_8003);
            wait_frm(2);
            // LSB left out: it is released at the very fall the codec samples
            chk("slow_word", 32'h5b, {25'h0, word[31:25]});
            last = 1'b0;
            while (!(last && pcm_out_oe === 1'b0)) begin
                last = pcm_out_oe;
                @(posedge sys_clk);
            end
            chk("zfall", 32'h0, {31'h0, pcm_clk_o});
            n = 0;
            while (pcm_clk_o === 1'b0) begin
                @(posedge sys_clk);
                n = n + 1;
            end
            chk("half_512k", 32'h30, n);
        end
    endtask
    initial begin
        repeat (3) @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
        t_regs;
        t_multi;
        t_sync_off;
        t_pad;
        t_slave;
        t_slow;
        tally_and_finish;
    end
endmodule
